// ===== hw/swe_pkg.sv
package swe_pkg;

  localparam int NUM_PINS = 11;

  // register byte offsets
  localparam logic [11:0] OFF_PINCFG  = 12'h000;
  localparam logic [11:0] OFF_LEDCFG  = 12'h004;
  localparam logic [11:0] OFF_WAKE    = 12'h008;
  localparam logic [11:0] OFF_PMCTL   = 12'h00c;
  localparam logic [11:0] OFF_IRQSTS  = 12'h010;
  localparam logic [11:0] OFF_MACWAKE = 12'h014;
  localparam logic [11:0] OFF_STATE   = 12'h018;

  // power management control fields
  localparam int PM_WAKE_STATUS_FIELD_LSB  = 0;
  localparam int PM_ENERGY_WAKE_ENABLE     = 2;
  localparam int PM_NETWORK_WAKE_ENABLE    = 3;
  localparam int PM_SUS_LSB   = 4;
  // wake register fields
  localparam int WK_POL_LSB   = 16;
  localparam int WK_LINKUP_EN = 31;
  // mac wake control fields
  localparam int MW_EXACT_ADDR_WAKE_ENABLE   = 0;
  localparam int MW_BROADCAST_WAKE_ENABLE  = 1;
  localparam int MW_PFDA_FR   = 8;
  localparam int MW_BCAST_FR  = 9;
  // pin control layout: pins 8..10 use ctl [2y+1:2y], dir at 8+y
  localparam int LED_DIR_LSB  = 8;

  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    SUS_FIRST  = 2'b00,
    SUS_SECOND = 2'b01,
    SUS_THIRD  = 2'b10,
    SUS_FOURTH = 2'b11
  } swe_sus_t;

  typedef enum logic [1:0] {
    ST_NORMAL  = 2'b01,
    ST_SUSPEND = 2'b10
  } swe_pwr_t;

endpackage : swe_pkg

// ===== hw/swe_pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module swe_pin_sync
  import swe_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_sync
);

  typedef struct packed {
    logic [NUM_PINS-1:0] s1;
    logic [NUM_PINS-1:0] s2;
  } swe_sync_t;

  swe_sync_t st_r;
  swe_sync_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.s2;

endmodule : swe_pin_sync
`default_nettype wire

// ===== hw/swe_wake_ctrl.sv
// Notes on behaviour
// - pin wakes only when enabled and level equals its polarity
// - enabled pin event in suspend returns to normal and raises wake
// - per-pin sticky status bits for pins 0..10
// - exact-address and broadcast wake each have an enable bit
// - status bit 1 wakes immediately; clear refused while MAC event high
// - network wake only in the first suspend state, code 00b
// - suspend mode field keeps its value after wake
// - in energy power-down PHY raises interrupt on line activity
// - status bit 0 wakes immediately; stays set while PHY irq high
// - energy wake uses second suspend state, code 01b
// - energy sensed in second state returns to normal with wake
// - link-up wake needs link-up enable and pin 7 enable
// - set pin 7 status causes immediate wake
// - link-up wake allowed in first or fourth suspend state
// - link-up sets pin 7 status, returns to normal, raises wake
// - in link-up use, external pin 7 level is ignored
// - mode codes 00b, 01b, 11b; network first, energy second only
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module swe_wake_ctrl
  import swe_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_PINS-1:0] pin_in,
  input  wire logic                suspend_req,
  input  wire logic                mac_wake_event,
  input  wire logic                mac_pfda_match,
  input  wire logic                mac_bcast_match,
  input  wire logic                transceiver_irq_flag,
  input  wire logic                phy_link_up,
  output logic                     energy_powerdown_bit,
  output logic                     remote_wake,
  output logic                     in_suspend
);

  typedef struct packed {
    logic [31:0] pincfg;
    logic [31:0] ledcfg;
    logic [31:0] wake;
    logic [1:0]  wake_status_field;
    logic        energy_wake_enable;
    logic        network_wake_enable;
    swe_sus_t    sus_mode;
    logic [NUM_PINS-1:0] pin_sts;
    logic        exact_addr_wake_enable;
    logic        broadcast_wake_enable;
    logic        pfda_fr;
    logic        bcast_fr;
    swe_pwr_t    pwr;
    logic        wake_out;
    logic [31:0] rdata;
    logic        link_prev;
    logic        ack;
  } swe_state_t;

  swe_state_t st_r;
  swe_state_t st_nxt;

  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_en;
  logic [NUM_PINS-1:0] pin_hit;
  logic [NUM_PINS-1:0] pin_lvl;
  logic [NUM_PINS-1:0] pin_clr;
  logic [31:0]         wmask;
  logic                wr_acc;
  logic                rd_acc;
  logic                link_rise;
  logic                any_wake;
  logic                sus_allow_wol;
  logic                sus_allow_ed;
  logic                sus_allow_link;
  logic [31:0]         rd_val;
  logic                mapped;
  logic                access;

  // synchronise pins before any comparison
  // two-stage synchroniser
  swe_pin_sync u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   (pin_in),
    .pin_sync (pin_sync)
  );

  function automatic logic [31:0] byte_mask(input logic [3:0] s);
    byte_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : byte_mask

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  function automatic logic hit(input logic [11:0] off);
    hit = (paddr == off);
  endfunction : hit

  // read data is latched in the first access cycle and handed over in
  // the second, where pready is high and a write lands
  assign access = psel & penable;
  assign wr_acc = access & pwrite & st_r.ack;
  assign rd_acc = access & ~pwrite & ~st_r.ack;
  assign wmask  = byte_mask(pstrb);

  always_comb begin
    rd_val = RST_ZERO;
    mapped = 1'b1;
    if (hit(OFF_PINCFG)) begin
      rd_val = st_r.pincfg;
    end else if (hit(OFF_LEDCFG)) begin
      rd_val = st_r.ledcfg;
    end else if (hit(OFF_WAKE)) begin
      rd_val = st_r.wake;
    end else if (hit(OFF_PMCTL)) begin
      rd_val[PM_WAKE_STATUS_FIELD_LSB +: 2] = st_r.wake_status_field;
      rd_val[PM_ENERGY_WAKE_ENABLE]         = st_r.energy_wake_enable;
      rd_val[PM_NETWORK_WAKE_ENABLE]        = st_r.network_wake_enable;
      rd_val[PM_SUS_LSB +: 2]  = st_r.sus_mode;
    end else if (hit(OFF_IRQSTS)) begin
      rd_val[NUM_PINS-1:0] = st_r.pin_sts;
    end else if (hit(OFF_MACWAKE)) begin
      rd_val[MW_EXACT_ADDR_WAKE_ENABLE]  = st_r.exact_addr_wake_enable;
      rd_val[MW_BROADCAST_WAKE_ENABLE] = st_r.broadcast_wake_enable;
      rd_val[MW_PFDA_FR]  = st_r.pfda_fr;
      rd_val[MW_BCAST_FR] = st_r.bcast_fr;
    end else if (hit(OFF_STATE)) begin
      rd_val[0] = (st_r.pwr == ST_SUSPEND);
      rd_val[1] = st_r.wake_out;
    end else begin
      // unmapped reads return zero and raise pslverr
      mapped = 1'b0;
    end
  end

  // per-pin enable and level after polarity
  always_comb begin
    pin_en = st_r.wake[NUM_PINS-1:0];
    for (int i = 0; i < NUM_PINS; i++) begin
      pin_lvl[i] = pin_sync[i] ~^ st_r.wake[WK_POL_LSB + i];
    end
    // pin 7 level ignored in link-up use
    // pin 7 then follows the internal link indication only
    if (st_r.wake[WK_LINKUP_EN]) begin
      pin_lvl[7] = 1'b0;
    end
    pin_hit = pin_en & pin_lvl;
  end

  // rising link is the event; a link that stays up never wakes
  assign link_rise = phy_link_up & ~st_r.link_prev;

  assign sus_allow_wol  = (st_r.sus_mode == SUS_FIRST);
  assign sus_allow_ed   = (st_r.sus_mode == SUS_SECOND);
  // link-up in first or fourth state
  assign sus_allow_link = (st_r.sus_mode == SUS_FIRST) |
                          (st_r.sus_mode == SUS_FOURTH);

  always_comb begin
    st_nxt           = st_r;
    st_nxt.link_prev = phy_link_up;
    st_nxt.wake_out  = 1'b0;
    // ack marks the second access cycle and drops with the transfer
    st_nxt.ack       = access & ~st_r.ack;
    pin_clr          = '0;
    if (rd_acc) begin
      st_nxt.rdata = rd_val;
    end
    if (wr_acc) begin
      unique case (1'b1)
        hit(OFF_PINCFG): st_nxt.pincfg = merge(st_r.pincfg, pwdata, wmask);
        hit(OFF_LEDCFG): st_nxt.ledcfg = merge(st_r.ledcfg, pwdata, wmask);
        hit(OFF_WAKE):   st_nxt.wake   = merge(st_r.wake, pwdata, wmask);
        hit(OFF_PMCTL): begin
          if (pstrb[0]) begin
            // write one clears status bits
            st_nxt.wake_status_field     = st_r.wake_status_field & ~pwdata[PM_WAKE_STATUS_FIELD_LSB +: 2];
            st_nxt.energy_wake_enable    = pwdata[PM_ENERGY_WAKE_ENABLE];
            st_nxt.network_wake_enable   = pwdata[PM_NETWORK_WAKE_ENABLE];
            st_nxt.sus_mode = swe_sus_t'(pwdata[PM_SUS_LSB +: 2]);
          end
        end
        hit(OFF_IRQSTS): begin
          pin_clr = pwdata[NUM_PINS-1:0] & wmask[NUM_PINS-1:0];
        end
        hit(OFF_MACWAKE): begin
          if (pstrb[0]) begin
            st_nxt.exact_addr_wake_enable  = pwdata[MW_EXACT_ADDR_WAKE_ENABLE];
            st_nxt.broadcast_wake_enable = pwdata[MW_BROADCAST_WAKE_ENABLE];
          end
          // received flags clear by writing ones on lane 1
          if (pstrb[1]) begin
            st_nxt.pfda_fr  = st_r.pfda_fr & ~pwdata[MW_PFDA_FR];
            st_nxt.bcast_fr = st_r.bcast_fr & ~pwdata[MW_BCAST_FR];
          end
        end
        default: ;
      endcase
    end
    // sticky pin status, set beats clear
    st_nxt.pin_sts = (st_r.pin_sts & ~pin_clr) | pin_hit;
    // link-up sets pin 7 status only where the mode admits it
    if (st_r.wake[WK_LINKUP_EN] & st_r.wake[7] & link_rise &
        sus_allow_link) begin
      st_nxt.pin_sts[7] = 1'b1;
    end
    if (st_r.exact_addr_wake_enable & mac_pfda_match) begin
      st_nxt.pfda_fr = 1'b1;
    end
    if (st_r.broadcast_wake_enable & mac_bcast_match) begin
      st_nxt.bcast_fr = 1'b1;
    end
    // bit 1 held while MAC event high
    if (mac_wake_event) begin
      st_nxt.wake_status_field[1] = 1'b1;
    end
    // bit 0 held while PHY irq high
    if (transceiver_irq_flag) begin
      st_nxt.wake_status_field[0] = 1'b1;
    end
    unique case (st_r.pwr)
      ST_NORMAL: begin
        if (suspend_req) begin
          st_nxt.pwr = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (any_wake) begin
          // back to normal with wake request
          st_nxt.pwr      = ST_NORMAL;
          st_nxt.wake_out = 1'b1;
        end
      end
      default: st_nxt.pwr = ST_NORMAL;
    endcase
  end

  // a set status bit wakes at once, so pending events must be cleared
  always_comb begin
    any_wake = 1'b0;
    // stored pin status wakes, including pin 7
    if (|st_r.pin_sts) begin
      any_wake = 1'b1;
    end
    if (sus_allow_link & st_r.wake[WK_LINKUP_EN] & st_r.wake[7] &
        link_rise) begin
      any_wake = 1'b1;
    end
    if (sus_allow_wol & st_r.network_wake_enable & st_r.wake_status_field[1]) begin
      any_wake = 1'b1;
    end
    if (sus_allow_ed & st_r.energy_wake_enable & st_r.wake_status_field[0]) begin
      any_wake = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= '0;
      st_r.pwr  <= ST_NORMAL;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.rdata;
  // one wait state so read data comes from a flop
  assign pready  = access & st_r.ack;
  // error only qualifies the completing cycle, paired with pready
  assign pslverr = pready & ~mapped;
  assign remote_wake = st_r.wake_out;
  assign in_suspend  = (st_r.pwr == ST_SUSPEND);
  // PHY powered down while armed for energy in suspend
  assign energy_powerdown_bit = in_suspend & st_r.energy_wake_enable & sus_allow_ed;

endmodule : swe_wake_ctrl
`default_nettype wire

// ===== tb/swe_wake_checker.sv
`timescale 1ns/10ps
`default_nettype none
module swe_wake_checker (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        suspend_req,
  input  wire logic        transceiver_irq_flag,
  input  wire logic        energy_powerdown_bit,
  input  wire logic        remote_wake,
  input  wire logic        in_suspend
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wake_one_cycle_a: assert property (
    remote_wake |=> !remote_wake) else $error("wake pulse too long");
  wake_from_sus_a: assert property (
    $rose(remote_wake) |-> $past(in_suspend)) else $error("wake not from suspend");
  wake_leaves_a: assert property (
    remote_wake |-> !in_suspend) else $error("still suspended at wake");
  sus_entry_a: assert property (
    $rose(in_suspend) |-> $past(suspend_req)) else $error("unrequested suspend");
  ed_only_sus_a: assert property (
    energy_powerdown_bit |-> in_suspend) else $error("powerdown outside suspend");
  ed_wake_a: assert property (
    energy_powerdown_bit && transceiver_irq_flag |-> ##[1:3] remote_wake)
    else $error("energy did not wake");
  apb_ready_a: assert property (
    psel && penable && !pready |=> pready) else $error("ready missing");
  apb_wait_a: assert property (
    psel && !penable |=> !pready) else $error("ready without wait state");
  slverr_qual_a: assert property (
    pslverr |-> psel && penable) else $error("stray slave error");
  rdata_hold_a: assert property (
    !(psel && penable && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
endmodule : swe_wake_checker
bind swe_wake_ctrl swe_wake_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .suspend_req(suspend_req), .transceiver_irq_flag(transceiver_irq_flag),
  .energy_powerdown_bit(energy_powerdown_bit),
  .remote_wake(remote_wake), .in_suspend(in_suspend));
`default_nettype wire

// ===== tb/swe_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module swe_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic sus_go,
  input  wire logic remote_wake,
  output logic      suspend_req,
  output int        wake_cnt
);
  // signals suspend one clock after sus_go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      suspend_req <= 1'b0;
      wake_cnt    <= 0;
    end else begin
      suspend_req <= sus_go;
      wake_cnt    <= wake_cnt + int'(remote_wake);
    end
  end
endmodule : swe_host_model
`default_nettype wire

// ===== tb/tb_swe_wake_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
module tb_swe_wake_ctrl import swe_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, sus_go = 1'b0, serr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, q, prdata;
  logic [NUM_PINS-1:0] pin_in = '0;
  logic mac_ev = 1'b0, irq = 1'b0, link = 1'b0, w;
  logic pfda = 1'b0, bcast = 1'b0;
  logic pready, pslverr, suspend_req, edpd, remote_wake, in_suspend;
  int error_cnt = 0, num_checks = 0, wake_cnt;
  always #50 pclk = ~pclk;
  swe_wake_ctrl u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .suspend_req(suspend_req), .mac_wake_event(mac_ev),
    .mac_pfda_match(pfda), .mac_bcast_match(bcast),
    .transceiver_irq_flag(irq), .phy_link_up(link),
    .energy_powerdown_bit(edpd), .remote_wake(remote_wake),
    .in_suspend(in_suspend));
  swe_host_model u_host (.pclk(pclk), .presetn(presetn), .sus_go(sus_go),
    .remote_wake(remote_wake), .suspend_req(suspend_req),
    .wake_cnt(wake_cnt));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin error_cnt++; complete_run(); end
    serr = pslverr;
    q = prdata;
    psel <= 1'b0; penable <= 1'b0;
  endtask : xfer
  task automatic wait_wake(input int n);
    w = 1'b0;
    repeat (n) begin
      @(posedge pclk);
      if (remote_wake === 1'b1) begin w = 1'b1; break; end
    end
  endtask : wait_wake
  task automatic suspend();
    @(posedge pclk); sus_go <= 1'b1;
    @(posedge pclk); sus_go <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(in_suspend, 1);
  endtask : suspend
  task automatic t_reset();
    xfer(0, OFF_PMCTL, 0); chk(q, RST_ZERO);
    xfer(0, OFF_STATE, 0); chk(q, RST_ZERO);
    xfer(0, 12'h040, 0); chk(serr, 1); chk(q, RST_ZERO);
  endtask : t_reset
  task automatic t_pin();
    xfer(1, OFF_PINCFG, 0); xfer(1, OFF_LEDCFG, 0);
    xfer(1, OFF_WAKE, 32'h0018_0018); xfer(1, OFF_PMCTL, 32'h0000_0020);
    suspend(); pin_in <= 11'h020; wait_wake(12); chk(w, 0);
    pin_in <= 11'h008; wait_wake(12); chk(w, 1);
    chk(in_suspend, 0);
    pin_in <= '0; xfer(0, OFF_IRQSTS, 0); chk(q, 32'h0000_0008);
    xfer(1, OFF_IRQSTS, 32'h0000_07ff); xfer(0, OFF_IRQSTS, 0); chk(q, 0);
    xfer(1, OFF_WAKE, 0);
  endtask : t_pin
  task automatic t_energy();
    irq <= 1'b1; xfer(1, OFF_PMCTL, 1); xfer(0, OFF_PMCTL, 0);
    chk(q, 32'h0000_0001);
    irq <= 1'b0; xfer(1, OFF_PMCTL, 1); xfer(0, OFF_PMCTL, 0); chk(q, 0);
    xfer(1, OFF_PMCTL, 32'h0000_0014); suspend(); chk(edpd, 1);
    irq <= 1'b1; wait_wake(8); chk(w, 1);
    irq <= 1'b0; xfer(0, OFF_PMCTL, 0); chk(q, 32'h0000_0015);
    xfer(1, OFF_PMCTL, 1);
  endtask : t_energy
  task automatic t_wol();
    // MAC event held high while clearing, so bit 1 stays set
    mac_ev <= 1'b1; xfer(1, OFF_PMCTL, 2); xfer(0, OFF_PMCTL, 0);
    chk(q, 32'h0000_0002);
    mac_ev <= 1'b0; xfer(1, OFF_PMCTL, 2); xfer(0, OFF_PMCTL, 0); chk(q, 0);
    xfer(1, OFF_MACWAKE, 3); xfer(0, OFF_MACWAKE, 0); chk(q, 3);
    pfda <= 1'b1; bcast <= 1'b1; @(posedge pclk);
    pfda <= 1'b0; bcast <= 1'b0;
    xfer(0, OFF_MACWAKE, 0); chk(q, 32'h0000_0303);
    xfer(1, OFF_MACWAKE, 32'h0000_0303);
    xfer(0, OFF_MACWAKE, 0); chk(q, 3);
    xfer(1, OFF_PMCTL, 32'h0000_0008); suspend();
    mac_ev <= 1'b1; wait_wake(8); chk(w, 1);
    mac_ev <= 1'b0; xfer(0, OFF_PMCTL, 0); chk(q, 32'h0000_000a);
    xfer(1, OFF_PMCTL, 2);
  endtask : t_wol
  task automatic t_link();
    xfer(1, OFF_PINCFG, 0);
    // link is down while link-up wake is armed
    xfer(1, OFF_WAKE, 32'h8000_0080); xfer(1, OFF_PMCTL, 32'h0000_0030);
    suspend(); wait_wake(12); chk(w, 0);
    link <= 1'b1; wait_wake(8); chk(w, 1);
    xfer(0, OFF_IRQSTS, 0); chk(q, 32'h0000_0080);
    suspend(); wait_wake(8); chk(w, 1);
    xfer(1, OFF_IRQSTS, 32'h0000_0080); xfer(0, OFF_IRQSTS, 0); chk(q, 0);
    link <= 1'b0; xfer(1, OFF_PMCTL, 32'h0000_0010);
    suspend(); link <= 1'b1; wait_wake(8); chk(w, 0);
    link <= 1'b0; xfer(1, OFF_PMCTL, 0);
    link <= 1'b1; wait_wake(8); chk(w, 1);
    xfer(0, OFF_IRQSTS, 0); chk(q, 32'h0000_0080);
  endtask : t_link
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset(); t_pin(); t_energy(); t_wol(); t_link();
    chk(32'(wake_cnt), 32'd6);
    complete_run();
  end
endmodule : tb_swe_wake_ctrl
`default_nettype wire
